// >>> jpd_cfg.svh
/*
  Constants for the programming data path behind the test port: instruction
  codes, chain widths, the unlock signature, command opcodes and reset time-outs.
  Assumes a 20 MHz core clock; included by bare name, definitions only.
*/
`ifndef JPD_CFG_SVH
`define JPD_CFG_SVH

// ************************************************************
// Instruction register
// ************************************************************
`define JPD_IR_W          4
`define JPD_IR_UNLOCK     4'h4
`define JPD_IR_COMMAND    4'h5
`define JPD_IR_FILL       4'h6
`define JPD_IR_DUMP       4'h7
`define JPD_IR_HOLD_RST   4'hC
`define JPD_IR_BYPASS     4'hF
`define JPD_IR_CAPTURE    4'h1

// ************************************************************
// Data chains
// ************************************************************
`define JPD_CMD_W         15
`define JPD_BYTE_W        8
`define JPD_KEY_W         16
`define JPD_KEY_SIG       16'hA370
`define JPD_KEY_RST       16'h0000
`define JPD_ADDR_W        16
`define JPD_OP_HI         14
`define JPD_OP_LO         8
`define JPD_OP_LD_ADDR_H  7'h07
`define JPD_OP_LD_ADDR_L  7'h03
`define JPD_ENTRY_W       25

// ************************************************************
// Reset time-out after the hold chain releases
// ************************************************************
`define JPD_CLK_MHZ       20
`define JPD_TMO_W         12
`define JPD_TMO0_NS       1000
`define JPD_TMO1_NS       16000
`define JPD_TMO2_NS       65000
`define JPD_TMO3_NS       200000
`define JPD_NS_TO_CYC(ns) (((ns) * `JPD_CLK_MHZ + 999) / 1000)
`define JPD_TMO0_CYC      `JPD_NS_TO_CYC(`JPD_TMO0_NS)
`define JPD_TMO1_CYC      `JPD_NS_TO_CYC(`JPD_TMO1_NS)
`define JPD_TMO2_CYC      `JPD_NS_TO_CYC(`JPD_TMO2_NS)
`define JPD_TMO3_CYC      `JPD_NS_TO_CYC(`JPD_TMO3_NS)

`endif

// >>> jpd_pkg.sv
/*
  Types shared by the programming data path: the test access port states.
  Assumes the constants header is included by any user of the numbers.
*/
package jpd_pkg;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
    TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
    TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
  } jpd_tap_state_t;

endpackage : jpd_pkg

// >>> jpd_pair_buf.sv
/*
  Two-entry buffer with valid and ready on both sides; outputs are registers.
  Assumes one clock, synchronous active-low reset and a freezing clock enable.
*/
`timescale 1ns/1ps
`default_nettype none

module jpd_pair_buf #(
  parameter int W = 25
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic         clk_en,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  logic         tail_valid;
  logic [W-1:0] tail_data;
  wire          push = in_valid & in_ready;
  wire          pop  = out_valid & out_ready;
  wire          head_free = ~out_valid | pop;

  // Ready only depends on the tail flop, so no path runs from out_ready to in_ready
  assign in_ready = ~tail_valid;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      out_valid  <= 1'b0;
      tail_valid <= 1'b0;
    end else if (clk_en) begin
      if (head_free) begin
        out_valid  <= tail_valid | push;
        tail_valid <= 1'b0;
      end else if (push) begin
        tail_valid <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (clk_en) begin
      if (head_free) begin
        out_data <= tail_valid ? tail_data : in_data;
      end
      if (push && !head_free) begin
        tail_data <= in_data;
      end
    end
  end

endmodule : jpd_pair_buf

`default_nettype wire

// >>> jpd_prog_port.sv
/*
  Programming data registers behind the test access port: hold-reset chain,
  unlock key, command chain and page byte chain with page fill and page dump.
  Assumes the test clock and pins arrive asynchronously and are oversampled by
  core_clk (test clock well below a quarter of core_clk); the flash read port
  answers combinationally within one core cycle.
*/
// Contract
// - Command instruction selects fifteen-bit command chain
// - Capture loads previous command result into chain
// - Shift moves chain one bit per test clock
// - Update presents shifted command to flash inputs
// - Idle after command update gives one execute pulse
// - Page fill selects low eight command bits
// - Fill update buffers byte, written within eleven clocks
// - Fill updates alternate low then high byte
// - Fill address pre-increments before each low byte except the first write
// - Page dump selects the same low eight bits
// - Dump capture returns low then high byte
// - Dump address post-increments after each high byte
// - Hold chain one keeps the core in reset
// - Release stretches reset by fuse-chosen time-out
// - Hold chain drives reset unlatched, even mid-shift
// - Programming allowed only on exact signature match
// - Unlock key clears on power-on reset
// - All chains shift least significant bit first
// - Unlock takes effect at data register update while unlock instruction is loaded
// - Instruction register is four bits wide
`timescale 1ns/1ps
`default_nettype none
`include "jpd_cfg.svh"

module jpd_prog_port
  import jpd_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     nrst,
  input  wire logic                     clk_en,
  input  wire logic                     tck_pin,
  input  wire logic                     tms_pin,
  input  wire logic                     tdi_pin,
  output logic                          tdo_pin,
  output logic                          tdo_oe,
  input  wire logic [1:0]               clock_option_sel,
  output logic                          mcu_reset_hold,
  output logic                          prog_enabled,
  input  wire logic [`JPD_CMD_W-1:0]    prog_result,
  output logic [`JPD_CMD_W-1:0]         flash_cmd,
  output logic                          flash_cmd_strobe,
  output logic                          flash_exec,
  output logic [`JPD_ADDR_W-1:0]        flash_rd_addr,
  input  wire logic [`JPD_ADDR_W-1:0]   flash_rd_data,
  output logic                          page_wr_valid,
  input  wire logic                     page_wr_ready,
  output logic                          page_wr_high,
  output logic [`JPD_ADDR_W-1:0]        page_wr_addr,
  output logic [`JPD_BYTE_W-1:0]        page_wr_byte
);

  // ************************************************************
  // Pin synchronisers and test clock edges
  // ************************************************************
  logic [2:0] tck_sync;
  logic [1:0] tms_sync;
  logic [1:0] tdi_sync;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tck_sync <= 3'h0;
      tms_sync <= 2'h0;
      tdi_sync <= 2'h0;
    end else if (clk_en) begin
      tck_sync <= {tck_sync[1:0], tck_pin};
      tms_sync <= {tms_sync[0], tms_pin};
      tdi_sync <= {tdi_sync[0], tdi_pin};
    end
  end

  // Edges look only at stages two and three, never at the first flop
  wire tck_rise = tck_sync[1] & ~tck_sync[2];
  wire tck_fall = ~tck_sync[1] & tck_sync[2];
  wire tms_s    = tms_sync[1];
  wire tdi_s    = tdi_sync[1];

  // ************************************************************
  // Test access port controller
  // ************************************************************
  jpd_tap_state_t tap;
  jpd_tap_state_t next_tap;

  always_comb begin
    unique case (tap)
      TAP_RESET:  next_tap = tms_s ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: next_tap = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_tap = tms_s ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  next_tap = tms_s ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: next_tap = tms_s ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR:  next_tap = tms_s ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: next_tap = tms_s ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: next_tap = tms_s ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: next_tap = tms_s ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  next_tap = tms_s ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: next_tap = tms_s ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR:  next_tap = tms_s ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: next_tap = tms_s ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tap <= TAP_RESET;
    end else if (clk_en && tck_rise) begin
      tap <= next_tap;
    end
  end

  // Actions happen on each rising test clock edge taken while in the named state
  wire act_cap_dr = tck_rise & (tap == TAP_CAP_DR);
  wire act_sh_dr  = tck_rise & (tap == TAP_SH_DR);
  wire act_upd_dr = tck_rise & (tap == TAP_UPD_DR);
  wire act_cap_ir = tck_rise & (tap == TAP_CAP_IR);
  wire act_sh_ir  = tck_rise & (tap == TAP_SH_IR);
  wire act_upd_ir = tck_rise & (tap == TAP_UPD_IR);
  wire act_idle   = tck_rise & (tap == TAP_IDLE);

  // ************************************************************
  // Instruction register
  // ************************************************************
  logic [`JPD_IR_W-1:0] ir;
  logic [`JPD_IR_W-1:0] ir_shift;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ir       <= `JPD_IR_BYPASS;
      ir_shift <= `JPD_IR_CAPTURE;
    end else if (clk_en) begin
      if (tck_rise && tap == TAP_RESET) begin
        ir <= `JPD_IR_BYPASS;
      end else if (act_upd_ir) begin
        ir <= ir_shift;
      end
      if (act_cap_ir) begin
        ir_shift <= `JPD_IR_CAPTURE;
      end else if (act_sh_ir) begin
        ir_shift <= {tdi_s, ir_shift[`JPD_IR_W-1:1]};
      end
    end
  end

  wire sel_unlock  = (ir == `JPD_IR_UNLOCK);
  wire sel_command = (ir == `JPD_IR_COMMAND);
  wire sel_fill    = (ir == `JPD_IR_FILL);
  wire sel_dump    = (ir == `JPD_IR_DUMP);
  wire sel_hold    = (ir == `JPD_IR_HOLD_RST);
  wire sel_byte    = sel_fill | sel_dump;
  wire sel_bypass  = ~(sel_unlock | sel_command | sel_byte | sel_hold);

  // ************************************************************
  // Data chains
  // ************************************************************
  logic [`JPD_CMD_W-1:0]  cmd_chain;
  logic [`JPD_KEY_W-1:0]  key_chain;
  logic                   hold_bit;
  logic                   bypass_bit;
  logic                   fill_high;
  logic                   fill_first;
  logic                   dump_high;
  logic [`JPD_ADDR_W-1:0] word_addr;

  // Page byte is the low end of the command chain, one flop set for both
  wire [`JPD_BYTE_W-1:0] dump_byte = dump_high ? flash_rd_data[15:8] : flash_rd_data[7:0];
  wire [`JPD_BYTE_W-1:0] byte_shifted = {tdi_s, cmd_chain[`JPD_BYTE_W-1:1]};
  wire [`JPD_CMD_W-1:0]  cmd_shifted  = {tdi_s, cmd_chain[`JPD_CMD_W-1:1]};

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cmd_chain <= {`JPD_CMD_W{1'b0}};
    end else if (clk_en) begin
      if (act_cap_dr && sel_command) begin
        cmd_chain <= prog_result;
      end else if (act_cap_dr && sel_dump && prog_enabled) begin
        cmd_chain[`JPD_BYTE_W-1:0] <= dump_byte;
      end else if (act_sh_dr && sel_command) begin
        cmd_chain <= cmd_shifted;
      end else if (act_sh_dr && sel_byte) begin
        cmd_chain[`JPD_BYTE_W-1:0] <= byte_shifted;
      end
    end
  end

  // Key clears only on power-on reset; a test logic reset leaves it alone
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      key_chain    <= `JPD_KEY_RST;
      prog_enabled <= 1'b0;
    end else if (clk_en) begin
      if (act_sh_dr && sel_unlock) begin
        key_chain <= {tdi_s, key_chain[`JPD_KEY_W-1:1]};
      end
      if (act_upd_dr && sel_unlock) begin
        prog_enabled <= (key_chain == `JPD_KEY_SIG);
      end
    end
  end

  // Hold bit is the chain itself with no update stage
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      hold_bit   <= 1'b0;
      bypass_bit <= 1'b0;
    end else if (clk_en) begin
      if (act_sh_dr && sel_hold) begin
        hold_bit <= tdi_s;
      end
      if (act_cap_dr && sel_bypass) begin
        bypass_bit <= 1'b0;
      end else if (act_sh_dr && sel_bypass) begin
        bypass_bit <= tdi_s;
      end
    end
  end

  // ************************************************************
  // Test data out, changed on the falling test clock edge
  // ************************************************************
  wire dr_lsb = sel_unlock  ? key_chain[0] :
                sel_hold    ? hold_bit     :
                sel_bypass  ? bypass_bit   : cmd_chain[0];
  wire in_shift_dr = (tap == TAP_SH_DR);
  wire in_shift_ir = (tap == TAP_SH_IR);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tdo_pin <= 1'b0;
      tdo_oe  <= 1'b0;
    end else if (clk_en && tck_fall) begin
      tdo_pin <= in_shift_ir ? ir_shift[0] : dr_lsb;
      tdo_oe  <= in_shift_dr | in_shift_ir;
    end
  end

  // ************************************************************
  // Command path to the flash controller
  // ************************************************************
  logic exec_armed;
  wire  cmd_update = act_upd_dr & sel_command & prog_enabled;
  wire [6:0] cmd_op = cmd_chain[`JPD_OP_HI:`JPD_OP_LO];

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      flash_cmd        <= {`JPD_CMD_W{1'b0}};
      flash_cmd_strobe <= 1'b0;
      flash_exec       <= 1'b0;
      exec_armed       <= 1'b0;
    end else if (clk_en) begin
      flash_cmd_strobe <= cmd_update;
      flash_exec       <= act_idle & exec_armed;
      if (cmd_update) begin
        flash_cmd  <= cmd_chain;
        exec_armed <= 1'b1;
      end else if (act_idle) begin
        exec_armed <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Word address counter shared by fill and dump
  // ************************************************************
  wire fill_update = act_upd_dr & sel_fill & prog_enabled;
  wire dump_cap    = act_cap_dr & sel_dump & prog_enabled;
  wire fill_step   = fill_update & ~fill_high & ~fill_first;
  wire dump_step   = dump_cap & dump_high;
  wire ld_addr_h   = cmd_update & (cmd_op == `JPD_OP_LD_ADDR_H);
  wire ld_addr_l   = cmd_update & (cmd_op == `JPD_OP_LD_ADDR_L);
  wire [`JPD_ADDR_W-1:0] addr_inc  = word_addr + 16'h0001;
  wire [`JPD_ADDR_W-1:0] fill_addr = fill_step ? addr_inc : word_addr;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      word_addr <= 16'h0000;
    end else if (clk_en) begin
      if (ld_addr_h) begin
        word_addr[15:8] <= cmd_chain[7:0];
      end else if (ld_addr_l) begin
        word_addr[7:0] <= cmd_chain[7:0];
      end else if (fill_step || dump_step) begin
        word_addr <= addr_inc;
      end
    end
  end

  assign flash_rd_addr = word_addr;

  // Byte alternation restarts whenever a new instruction is loaded
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      fill_high  <= 1'b0;
      fill_first <= 1'b1;
      dump_high  <= 1'b0;
    end else if (clk_en) begin
      if (act_upd_ir) begin
        fill_high  <= 1'b0;
        fill_first <= 1'b1;
        dump_high  <= 1'b0;
      end else begin
        if (fill_update) begin
          fill_high  <= ~fill_high;
          fill_first <= 1'b0;
        end
        if (dump_cap) begin
          dump_high <= ~dump_high;
        end
      end
    end
  end

  // ************************************************************
  // Page fill holding register and buffer
  // ************************************************************
  logic                    pend_valid;
  logic [`JPD_ENTRY_W-1:0] pend_entry;
  logic                    buf_in_ready;
  logic [`JPD_ENTRY_W-1:0] buf_out;

  // Holding flop waits for buffer room; a full buffer stalls it, not the byte
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pend_valid <= 1'b0;
      pend_entry <= {`JPD_ENTRY_W{1'b0}};
    end else if (clk_en) begin
      if (fill_update) begin
        pend_valid <= 1'b1;
        pend_entry <= {fill_high, fill_addr, cmd_chain[`JPD_BYTE_W-1:0]};
      end else if (buf_in_ready) begin
        pend_valid <= 1'b0;
      end
    end
  end

  jpd_pair_buf #(
    .W (`JPD_ENTRY_W)
  ) u_fill_buf (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .in_valid  (pend_valid),
    .in_data   (pend_entry),
    .in_ready  (buf_in_ready),
    .out_valid (page_wr_valid),
    .out_data  (buf_out),
    .out_ready (page_wr_ready)
  );

  assign page_wr_high = buf_out[`JPD_ENTRY_W-1];
  assign page_wr_addr = buf_out[`JPD_ENTRY_W-2:`JPD_BYTE_W];
  assign page_wr_byte = buf_out[`JPD_BYTE_W-1:0];

  // ************************************************************
  // Core reset hold and time-out
  // ************************************************************
  logic [`JPD_TMO_W-1:0] tmo_cnt;
  logic [`JPD_TMO_W-1:0] tmo_load;

  always_comb begin
    unique case (clock_option_sel)
      2'h0: tmo_load = `JPD_TMO_W'(`JPD_TMO0_CYC);
      2'h1: tmo_load = `JPD_TMO_W'(`JPD_TMO1_CYC);
      2'h2: tmo_load = `JPD_TMO_W'(`JPD_TMO2_CYC);
      2'h3: tmo_load = `JPD_TMO_W'(`JPD_TMO3_CYC);
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tmo_cnt <= {`JPD_TMO_W{1'b0}};
    end else if (clk_en) begin
      if (hold_bit) begin
        tmo_cnt <= tmo_load;
      end else if (tmo_cnt != {`JPD_TMO_W{1'b0}}) begin
        tmo_cnt <= tmo_cnt - `JPD_TMO_W'(1);
      end
    end
  end

  // Reset follows the hold bit directly, plus the running time-out
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      mcu_reset_hold <= 1'b0;
    end else if (clk_en) begin
      mcu_reset_hold <= hold_bit | (tmo_cnt != {`JPD_TMO_W{1'b0}});
    end
  end

endmodule : jpd_prog_port

`default_nettype wire

// >>> jpd_prog_port_props.sv
/* Assertions on the programming port outputs.
   Assumes bind onto jpd_prog_port, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
`include "jpd_cfg.svh"
module jpd_prog_port_props (
  input wire logic                  core_clk,
  input wire logic                  nrst,
  input wire logic [1:0]            clock_option_sel,
  input wire logic                  mcu_reset_hold,
  input wire logic                  prog_enabled,
  input wire logic [`JPD_CMD_W-1:0] flash_cmd,
  input wire logic                  flash_cmd_strobe,
  input wire logic                  flash_exec,
  input wire logic [15:0]           flash_rd_addr,
  input wire logic                  page_wr_valid,
  input wire logic                  page_wr_ready,
  input wire logic                  page_wr_high,
  input wire logic [15:0]           page_wr_addr,
  input wire logic [7:0]            page_wr_byte
);
  logic [12:0] hi_cnt;
  logic [12:0] tmo_cyc;
  logic        seen;
  logic        last_high;
  logic [15:0] last_addr;
  wire logic   hs;
  assign hs = page_wr_valid && page_wr_ready;
  assign tmo_cyc = clock_option_sel[1] ? (clock_option_sel[0] ? 13'(`JPD_TMO3_CYC) : 13'(`JPD_TMO2_CYC))
                                       : (clock_option_sel[0] ? 13'(`JPD_TMO1_CYC) : 13'(`JPD_TMO0_CYC));
  // Saturating count of held cycles; a release before the time-out shows here
  always_ff @(posedge core_clk) begin
    hi_cnt <= (!nrst || !mcu_reset_hold) ? '0 : hi_cnt + 13'(hi_cnt != '1);
    seen <= nrst && (seen || hs);
    if (hs) begin
      last_high <= page_wr_high;
      last_addr <= page_wr_addr;
    end
  end
  // ************
  // Properties
  // ************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  strobe_pulse_a: assert property (flash_cmd_strobe |=> !flash_cmd_strobe)
    else $error("command strobe too long");
  cmd_steady_a: assert property (!flash_cmd_strobe |-> $stable(flash_cmd))
    else $error("command changed without strobe");
  exec_pulse_a: assert property (flash_exec |=> !flash_exec)
    else $error("execute pulse too long");
  locked_quiet_a: assert property (!prog_enabled && !$past(prog_enabled) |-> !flash_cmd_strobe)
    else $error("command taken while locked");
  reset_stretch_a: assert property ($fell(mcu_reset_hold) |-> hi_cnt >= tmo_cyc)
    else $error("reset released before time-out");
  addr_step_a: assert property ($changed(flash_rd_addr) && !flash_cmd_strobe && !$past(flash_cmd_strobe)
    |-> flash_rd_addr == $past(flash_rd_addr) + 16'h0001)
    else $error("address moved by other than one");
  head_hold_a: assert property (page_wr_valid && !page_wr_ready |=> page_wr_valid
    && $stable({page_wr_high, page_wr_addr, page_wr_byte})) else $error("stalled head lost");
  byte_pair_a: assert property (hs && page_wr_high |-> seen && !last_high && page_wr_addr == last_addr)
    else $error("high byte out of pair");
  key_clear_a: assert property ($rose(nrst) |-> !prog_enabled)
    else $error("unlock survived reset");
  cover property (flash_exec);
  cover property (page_wr_valid && !page_wr_ready);
  cover property ($fell(mcu_reset_hold));
endmodule : jpd_prog_port_props
bind jpd_prog_port jpd_prog_port_props chk (.core_clk(core_clk), .nrst(nrst), .clock_option_sel(clock_option_sel),
  .mcu_reset_hold(mcu_reset_hold), .prog_enabled(prog_enabled), .flash_cmd(flash_cmd),
  .flash_cmd_strobe(flash_cmd_strobe), .flash_exec(flash_exec), .flash_rd_addr(flash_rd_addr),
  .page_wr_valid(page_wr_valid), .page_wr_ready(page_wr_ready), .page_wr_high(page_wr_high),
  .page_wr_addr(page_wr_addr), .page_wr_byte(page_wr_byte));
`default_nettype wire

// >>> jpd_flash_model.sv
/* Flash side model: read array, command result, stallable page sink.
   Assumes core_clk domain; reads answer combinationally. */
`timescale 1ns/1ps
`default_nettype none
module jpd_flash_model (
  input wire logic   core_clk,
  input wire logic   nrst,
  input wire logic   stall,
  input wire logic [15:0] rd_addr,
  output logic [15:0]     rd_data,
  output logic [14:0]     result,
  input wire logic        wr_valid,
  output logic            wr_ready,
  input wire logic [24:0] wr_entry
);
  logic [24:0] log_q[$];
  // Byte contents derived from the low address byte, so words repeat every 256 addresses
  assign rd_data = {~rd_addr[7:0], rd_addr[7:0]};
  assign result = 15'h2A5C;
  assign wr_ready = !stall;
  always @(posedge core_clk) begin
    if (nrst && wr_valid && wr_ready) log_q.push_back(wr_entry);
  end
endmodule : jpd_flash_model
`default_nettype wire

// >>> tb_top.sv
/* Testbench for the programming port, driven as a test-port host.
   Assumes 400 ns test clock, sampled by a 50 ns core clock. */
`timescale 1ns/1ps
`default_nettype none
`include "jpd_cfg.svh"
module tb_top;
  logic core_clk = 0, nrst = 0, tck = 0, tms = 1, tdi = 0, stall = 0, ce = 1;
  logic [1:0] sel = 2'h0;
  logic tdo, oe, hold, en, strb, exe, wv, wr, wh;
  logic [14:0] cmd, res;
  logic [15:0] ra, rd, wa, d;
  logic [7:0] wb;
  int errors = 0, comparisons = 0, execs = 0, strobes = 0;
  int tmo [4] = '{`JPD_TMO0_CYC, `JPD_TMO1_CYC, `JPD_TMO2_CYC, `JPD_TMO3_CYC};
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    execs <= execs + int'(exe === 1'b1);
    strobes <= strobes + int'(strb === 1'b1);
  end
  jpd_prog_port dut (.core_clk(core_clk), .nrst(nrst), .clk_en(ce), .tck_pin(tck), .tms_pin(tms),
    .tdi_pin(tdi), .tdo_pin(tdo), .tdo_oe(oe), .clock_option_sel(sel), .mcu_reset_hold(hold),
    .prog_enabled(en), .prog_result(res), .flash_cmd(cmd), .flash_cmd_strobe(strb), .flash_exec(exe),
    .flash_rd_addr(ra), .flash_rd_data(rd), .page_wr_valid(wv), .page_wr_ready(wr), .page_wr_high(wh),
    .page_wr_addr(wa), .page_wr_byte(wb));
  jpd_flash_model flash (.core_clk(core_clk), .nrst(nrst), .stall(stall), .rd_addr(ra), .rd_data(rd),
    .result(res), .wr_valid(wv), .wr_ready(wr), .wr_entry({wh, wa, wb}));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // One test clock: data set in the low half, output read mid high half
  task automatic tick(input logic ms, input logic di, output logic dout);
    tck <= 1'b0;
    tms <= ms;
    tdi <= di;
    repeat (4) @(posedge core_clk);
    tck <= 1'b1;
    repeat (2) @(posedge core_clk);
    dout = tdo;
    repeat (2) @(posedge core_clk);
  endtask : tick
  // Scan from idle back to idle, least significant bit first; extra idle clock runs a command
  task automatic scan(input logic ir, input int n, input logic [15:0] din, output logic [15:0] dout);
    logic b;
    dout = '0;
    tick(1'b1, 1'b0, b);
    if (ir) tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b0, b);
    tick(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
      if (i == 0) check(oe, 1);
    end
    tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b0, b);
    tick(1'b0, 1'b0, b);
    check(oe, 0);
  endtask : scan
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(en, 0);
    tick(1'b0, 1'b0, d[0]);
    scan(1, 4, 16'h000C, d);
    check(d, 16'h0001);
    scan(0, 1, 16'h0001, d);
    check(hold, 1);
    scan(1, 4, 16'h0005, d);
    scan(0, 15, 16'h0712, d);
    check(cmd, 0);
    scan(1, 4, 16'h0004, d);
    scan(0, 16, 16'hA371, d);
    check(en, 0);
    scan(0, 16, 16'hA370, d);
    check(en, 1);
    scan(1, 4, 16'h0005, d);
    scan(0, 15, 16'h0712, d);
    check(cmd, 15'h0712);
    scan(0, 15, 16'h0334, d);
    check(d, 16'h2A5C);
    check(ra, 16'h1234);
    scan(1, 4, 16'h0007, d);
    for (int k = 0; k < 4; k++) begin
      scan(0, 8, 16'h0000, d);
      check(d, k[0] ? 16'h00CB - k / 2 : 16'h0034 + k / 2);
    end
    check(ra, 16'h1236);
    scan(1, 4, 16'h0005, d);
    scan(0, 15, 16'h0700, d);
    scan(0, 15, 16'h0340, d);
    scan(1, 4, 16'h0006, d);
    stall <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      if (k == 3) stall <= 1'b0;
      scan(0, 8, 16'h00A0 + 16'(k), d);
    end
    repeat (20) @(posedge core_clk);
    check(flash.log_q.size(), 4);
    for (int k = 0; k < 4; k++) check(flash.log_q[k], {k[0], 16'h0040 + 16'(k / 2), 8'hA0 + 8'(k)});
    check(execs, 4);
    check(strobes, 4);
    scan(1, 4, 16'h000C, d);
    // Fuse choices one to three; a frozen clock enable must also freeze the time-out
    for (int s = 1; s < 4; s++) begin
      sel <= 2'(s);
      scan(0, 1, 16'h0001, d);
      scan(0, 1, 16'h0000, d);
      check(hold, 1);
      ce <= 1'b0;
      repeat (400) @(posedge core_clk);
      check(hold, 1);
      ce <= 1'b1;
      repeat (tmo[s] - 30) @(posedge core_clk);
      check(hold, 1);
      repeat (10) @(posedge core_clk);
      check(hold, 0);
    end
    nrst <= 1'b0;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(en, 0);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
